// ==== hdl/can_bit_sampling_irq.sv ====
// Bit timing, bus sampling, bus state and interrupt requests over APB
//
// What this block does
// - Timing register writable only in init mode
// - Bit 7 selects one or three samples
// - Single sampling takes sample-point level
// - Triple sampling takes majority of three
// - Bits 6:4 hold segment two length
// - Bits 3:0 hold segment one length
// - Four individually maskable interrupt outputs
// - Empty transmit buffers flag and interrupt
// - Received frame sets receive-full flag
// - Next foreground load sets flag again
// - Bus activity in sleep sets wake-up
// - Overrun or state change raises error interrupt
// - Bus state follows error counter values
// - Entering critical range sets status change
//
// Our own choices: the register addresses and the APB register port.
`include "can_timing_cfg.svh"
`default_nettype none
module can_bit_sampling_irq #(
  parameter int TX_CNT_W = 9,
  parameter int RX_CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire can_timing_pkg::reg_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx,
  input wire logic tq_tick,
  input wire logic sleep_mode,
  input wire logic [2:0] tx_buffer_empty,
  input wire logic rx_fg_loaded,
  input wire logic rx_overrun,
  input wire logic [TX_CNT_W-1:0] tx_err_cnt,
  input wire logic [RX_CNT_W-1:0] rx_err_cnt,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic init_acknowledge,
  output logic irq_wakeup,
  output logic irq_error,
  output logic irq_receive,
  output logic irq_transmit
);
  import can_timing_pkg::*;

  // All checks below run on the bus clock, quiet during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus-off needs a ninth transmit counter bit
  if (TX_CNT_W < 9 || RX_CNT_W < 8 || RX_CNT_W > TX_CNT_W) begin : g_bad_widths
    $error("error counter widths not supported");
  end

  logic [7:0] bit_timing_segments_r;
  logic init_request_r;
  logic wakeup_function_enable_r;
  logic [7:0] receive_irq_enable_reg_r;
  logic [2:0] transmit_irq_enable_reg_r;
  logic wakeup_flag_r, status_change_flag_r, overrun_flag_r;
  logic receive_full_flag_r;
  state_code_t transmitter_state_code_r, receiver_state_code_r;
  logic [2:0] tx_buffer_empty_flags_r;
  logic rx_meta_r, rx_sync_r, rx_prev_r;
  bit_phase_t phase_r;
  logic [3:0] qcnt_r;
  logic [1:0] triple_sample_select_hist_r;

  // Register fields
  logic triple_sample_select;
  logic [2:0] second_time_segment;
  logic [3:0] first_time_segment;
  assign triple_sample_select = bit_timing_segments_r[`TRIPLE_SAMPLE_SELECT_POS];
  assign second_time_segment = bit_timing_segments_r[`SECOND_TIME_SEGMENT_LSB +: 3];
  assign first_time_segment = bit_timing_segments_r[`FIRST_TIME_SEGMENT_LSB +: 4];

  // APB decode
  logic setup_ph, wr_acc;
  logic mapped;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite && !pslverr;
  always_comb begin
    unique case (paddr)
      `BTR_OFF, `CTRL_OFF, `RFLG_OFF, `RIER_OFF,
      `TFLG_OFF, `TIER_OFF, `BITSTAT_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Ready one cycle after setup, so every access phase is one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !mapped;
    end
  end

  // Init handshake: acknowledge follows request one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_request_r <= `CTRL_RST;
      wakeup_function_enable_r <= 1'b0;
      init_acknowledge <= 1'b0;
    end else begin
      if (wr_acc && paddr == `CTRL_OFF) begin
        init_request_r <= pwdata[`INIT_REQUEST_POS];
        wakeup_function_enable_r <= pwdata[`WAKEUP_FUNCTION_ENABLE_POS];
      end
      init_acknowledge <= init_request_r;
    end
  end

  // Timing register locked outside init mode; late writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_timing_segments_r <= `BTR_RST;
    end else if (wr_acc && paddr == `BTR_OFF && init_request_r &&
                 init_acknowledge) begin
      bit_timing_segments_r <= pwdata[7:0];
    end
  end
  btr_write_lock_a: assert property (
    wr_acc && paddr == `BTR_OFF && !(init_request_r && init_acknowledge)
    |=> $stable(bit_timing_segments_r))
    else $error("timing register changed outside init mode");

  // Enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_irq_enable_reg_r <= 8'h00;
      transmit_irq_enable_reg_r <= 3'h0;
    end else begin
      if (wr_acc && paddr == `RIER_OFF)
        receive_irq_enable_reg_r <= pwdata[7:0];
      if (wr_acc && paddr == `TIER_OFF)
        transmit_irq_enable_reg_r <= pwdata[2:0];
    end
  end

  // Bus pin synchroniser; the first stage is not looked at, the third keeps the previous level for wake-up edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= can_rx;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  // Quantum sequencer: sync, then segment one, then segment two
  logic triple_sample_select_evt;
  assign triple_sample_select_evt = tq_tick && phase_r == PH_SEG1 && qcnt_r == 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= PH_SYNC;
      qcnt_r <= 4'h0;
    end else if (init_acknowledge) begin
      phase_r <= PH_SYNC; // Held still while being configured
      qcnt_r <= 4'h0;
    end else if (tq_tick) begin
      unique case (phase_r)
        PH_SYNC: begin
          phase_r <= PH_SEG1;
          qcnt_r <= first_time_segment;
        end
        PH_SEG1: begin
          if (qcnt_r == 4'h0) begin
            phase_r <= PH_SEG2;
            qcnt_r <= {1'b0, second_time_segment};
          end else begin
            qcnt_r <= qcnt_r - 4'h1;
          end
        end
        PH_SEG2: begin
          if (qcnt_r == 4'h0) phase_r <= PH_SYNC;
          else qcnt_r <= qcnt_r - 4'h1;
        end
        default: phase_r <= PH_SYNC;
      endcase
    end
  end
  seg1_load_a: assert property (
    tq_tick && phase_r == PH_SYNC && !init_acknowledge
    |=> phase_r == PH_SEG1 && qcnt_r == $past(first_time_segment))
    else $error("segment one length not loaded");
  seg2_load_a: assert property (
    triple_sample_select_evt && !init_acknowledge
    |=> phase_r == PH_SEG2 && qcnt_r == {1'b0, $past(second_time_segment)})
    else $error("segment two length not loaded");

  // Samples of the last quanta; the current one closes the window
  logic maj_now;
  assign maj_now = (triple_sample_select_hist_r[1] & triple_sample_select_hist_r[0]) |
                   (triple_sample_select_hist_r[1] & rx_sync_r) |
                   (triple_sample_select_hist_r[0] & rx_sync_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      triple_sample_select_hist_r <= 2'h3;
    end else if (tq_tick) begin
      triple_sample_select_hist_r <= {triple_sample_select_hist_r[0], rx_sync_r};
    end
  end

  // Bit value at the sample point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit <= 1'b1;
      rx_bit_valid <= 1'b0;
    end else begin
      rx_bit_valid <= triple_sample_select_evt;
      if (triple_sample_select_evt)
        rx_bit <= triple_sample_select ? maj_now : rx_sync_r;
    end
  end
  single_sample_a: assert property (
    triple_sample_select_evt && !triple_sample_select |=> rx_bit == $past(rx_sync_r))
    else $error("single sample value wrong");
  triple_vote_a: assert property (
    triple_sample_select_evt && triple_sample_select |=> rx_bit == $past(maj_now) &&
    rx_bit_valid)
    else $error("majority vote value wrong");

  // Bus state from counters: ok, warning, error, bus-off
  function automatic state_code_t state_of(input logic [TX_CNT_W-1:0] c);
    if (c >= TX_CNT_W'(`OFF_LIM)) state_of = 2'h3;
    else if (c >= TX_CNT_W'(`ERR_LIM)) state_of = 2'h2;
    else if (c >= TX_CNT_W'(`WARN_LIM)) state_of = 2'h1;
    else state_of = 2'h0;
  endfunction

  state_code_t tx_state_now, rx_state_now;
  logic state_enter;
  assign tx_state_now = state_of(tx_err_cnt);
  // Receive counter cannot reach bus-off; cap its code at error
  assign rx_state_now = state_of(TX_CNT_W'(rx_err_cnt)) == 2'h3 ? 2'h2 :
                        state_of(TX_CNT_W'(rx_err_cnt));
  assign state_enter =
    (tx_state_now != transmitter_state_code_r && tx_state_now != 2'h0) ||
    (rx_state_now != receiver_state_code_r && rx_state_now != 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmitter_state_code_r <= 2'h0;
      receiver_state_code_r <= 2'h0;
    end else begin
      transmitter_state_code_r <= tx_state_now;
      receiver_state_code_r <= rx_state_now;
    end
  end

  // Flags clear by writing one; a same-cycle event still sets them
  logic [7:0] rflg_clr;
  logic wake_evt;
  assign rflg_clr = (wr_acc && paddr == `RFLG_OFF) ? pwdata[7:0] : 8'h00;
  assign wake_evt = sleep_mode && wakeup_function_enable_r &&
                    rx_prev_r && !rx_sync_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_flag_r <= 1'b0;
      status_change_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      receive_full_flag_r <= 1'b0;
    end else begin
      wakeup_flag_r <= wake_evt ||
        (wakeup_flag_r && !rflg_clr[`WAKEUP_FLAG_POS]);
      status_change_flag_r <= state_enter ||
        (status_change_flag_r && !rflg_clr[`STATUS_CHANGE_FLAG_POS]);
      overrun_flag_r <= rx_overrun ||
        (overrun_flag_r && !rflg_clr[`OVERRUN_FLAG_POS]);
      receive_full_flag_r <= rx_fg_loaded ||
        (receive_full_flag_r && !rflg_clr[`RXF_POS]);
    end
  end
  state_change_a: assert property (
    state_enter |=> status_change_flag_r &&
    transmitter_state_code_r == $past(tx_state_now))
    else $error("status change not flagged");

  // Empty buffers mirror the frame engine's scheduling state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_buffer_empty_flags_r <= 3'h7;
    else tx_buffer_empty_flags_r <= tx_buffer_empty;
  end

  // Four separately masked requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_wakeup <= 1'b0;
      irq_error <= 1'b0;
      irq_receive <= 1'b0;
      irq_transmit <= 1'b0;
    end else begin
      irq_wakeup <= wakeup_flag_r &&
        receive_irq_enable_reg_r[`WAKEUP_FLAG_POS];
      irq_error <= (status_change_flag_r &&
        receive_irq_enable_reg_r[`STATUS_CHANGE_FLAG_POS]) || (overrun_flag_r &&
        receive_irq_enable_reg_r[`OVERRUN_FLAG_POS]);
      irq_receive <= receive_full_flag_r &&
        receive_irq_enable_reg_r[`RXF_POS];
      irq_transmit <= |(tx_buffer_empty_flags_r &
        transmit_irq_enable_reg_r);
    end
  end
  rx_full_irq_a: assert property (
    rx_fg_loaded && receive_irq_enable_reg_r[`RXF_POS]
    |=> receive_full_flag_r ##1 irq_receive)
    else $error("receive flag or interrupt missing");
  wakeup_irq_a: assert property (
    wake_evt && receive_irq_enable_reg_r[`WAKEUP_FLAG_POS] &&
    !rflg_clr[`WAKEUP_FLAG_POS] |=> wakeup_flag_r ##1 irq_wakeup)
    else $error("wake-up flag or interrupt missing");
  // Enable must not be rewritten in the edge that registers the empty flags, one edge before the request
  tx_empty_irq_a: assert property (
    |(tx_buffer_empty & transmit_irq_enable_reg_r) &&
    !(wr_acc && paddr == `TIER_OFF) |=> ##1 irq_transmit)
    else $error("transmit interrupt missing");

  // Read data captured at setup so the access phase needs no wait
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      `BTR_OFF: rd_mux[7:0] = bit_timing_segments_r;
      `CTRL_OFF: begin
        rd_mux[`INIT_REQUEST_POS] = init_request_r;
        rd_mux[`WAKEUP_FUNCTION_ENABLE_POS] = wakeup_function_enable_r;
        rd_mux[`INIT_ACKNOWLEDGE_POS] = init_acknowledge;
      end
      `RFLG_OFF: begin
        rd_mux[`WAKEUP_FLAG_POS] = wakeup_flag_r;
        rd_mux[`STATUS_CHANGE_FLAG_POS] = status_change_flag_r;
        rd_mux[`RECEIVER_STATE_CODE_LSB +: 2] = receiver_state_code_r;
        rd_mux[`TRANSMITTER_STATE_CODE_LSB +: 2] = transmitter_state_code_r;
        rd_mux[`OVERRUN_FLAG_POS] = overrun_flag_r;
        rd_mux[`RXF_POS] = receive_full_flag_r;
      end
      `RIER_OFF: rd_mux[7:0] = receive_irq_enable_reg_r;
      `TFLG_OFF: rd_mux[2:0] = tx_buffer_empty_flags_r;
      `TIER_OFF: rd_mux[2:0] = transmit_irq_enable_reg_r;
      `BITSTAT_OFF: rd_mux[1:0] = {rx_sync_r, rx_bit};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (setup_ph) prdata <= rd_mux;
  end
endmodule
`default_nettype wire

// ==== hdl/can_timing_cfg.svh ====
// Register offsets, field positions, reset values and limits of the block
`ifndef CAN_TIMING_CFG_SVH
`define CAN_TIMING_CFG_SVH
`define BTR_OFF 8'h00
`define CTRL_OFF 8'h04
`define RFLG_OFF 8'h08
`define RIER_OFF 8'h0c
`define TFLG_OFF 8'h10
`define TIER_OFF 8'h14
`define BITSTAT_OFF 8'h18
`define TRIPLE_SAMPLE_SELECT_POS 7
`define SECOND_TIME_SEGMENT_LSB 4
`define FIRST_TIME_SEGMENT_LSB 0
`define INIT_REQUEST_POS 0
`define WAKEUP_FUNCTION_ENABLE_POS 1
`define INIT_ACKNOWLEDGE_POS 4
`define WAKEUP_FLAG_POS 7
`define STATUS_CHANGE_FLAG_POS 6
`define RECEIVER_STATE_CODE_LSB 4
`define TRANSMITTER_STATE_CODE_LSB 2
`define OVERRUN_FLAG_POS 1
`define RXF_POS 0
`define BTR_RST 8'h00
`define CTRL_RST 1'b0
`define WARN_LIM 96
`define ERR_LIM 128
`define OFF_LIM 256
`endif

// ==== hdl/can_timing_pkg.sv ====
// Types shared by the bit sampler and interrupt block
`default_nettype none
package can_timing_pkg;
  typedef enum logic [1:0] {PH_SYNC, PH_SEG1, PH_SEG2} bit_phase_t;
  typedef logic [1:0] state_code_t;
  typedef logic [7:0] reg_addr_t;
endpackage
`default_nettype wire

// ==== testbench/can_bus_node.sv ====
// Far-side bus node model: quantum ticks and random bus levels
`default_nettype none
module can_bus_node (
  input wire logic pclk,
  input wire logic presetn,
  output logic tq_tick,
  output logic can_rx,
  output logic [2:0] hist
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  // Level changes just after a tick, so it clears the 2-flop sync in time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      tq_tick <= 1'b0;
      can_rx <= 1'b1;
      hist <= 3'h7;
    end else begin
      div_r <= div_r + 2'h1;
      tq_tick <= (div_r == 2'h2);
      if (tq_tick) begin
        hist <= {hist[1:0], can_rx};
        can_rx <= 1'($urandom);
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_can_bit_sampling_and_irq.sv ====
// Self-checking bench for bit sampling, timing register and interrupts
`include "can_timing_cfg.svh"
`default_nettype none
module tb_can_bit_sampling_and_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sleep_mode = 1'b0, rx_fg_loaded = 1'b0;
  logic rx_overrun = 1'b0, pready, pslverr, can_rx, tq_tick, rx_bit;
  logic rx_bit_valid, init_ack, irq_w, irq_e, irq_r, irq_t, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] tx_empty = 3'h7, hist;
  logic [8:0] tx_cnt = 9'h000;
  logic [7:0] rx_cnt = 8'h00;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  int tx_tab[8] = '{95, 96, 127, 128, 255, 256, 0, 300};

  // Clock and free cycle count for bit spacing
  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  can_bit_sampling_irq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
    .tq_tick(tq_tick), .sleep_mode(sleep_mode), .tx_buffer_empty(tx_empty),
    .rx_fg_loaded(rx_fg_loaded), .rx_overrun(rx_overrun),
    .tx_err_cnt(tx_cnt), .rx_err_cnt(rx_cnt), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .init_acknowledge(init_ack),
    .irq_wakeup(irq_w), .irq_error(irq_e), .irq_receive(irq_r),
    .irq_transmit(irq_t));
  can_bus_node node_u (.pclk(pclk), .presetn(presetn), .tq_tick(tq_tick),
    .can_rx(can_rx), .hist(hist));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer plus an idle cycle, so psel never toggles in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  task automatic pulse(input logic ov);
    rx_fg_loaded <= !ov;
    rx_overrun <= ov;
    @(posedge pclk);
    rx_fg_loaded <= 1'b0;
    rx_overrun <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic maj(input logic [2:0] h);
    return (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
  endfunction

  function automatic logic [1:0] code(input int c);
    return c >= `OFF_LIM ? 2'h3 : c >= `ERR_LIM ? 2'h2 :
      c >= `WARN_LIM ? 2'h1 : 2'h0;
  endfunction

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0] btr, en, f;
    logic [1:0] ts, rs, pts, prs;
    int t1, t2, last;
    void'($urandom(99));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`BTR_OFF, `BTR_RST);
    chk({irq_w, irq_e, irq_r, irq_t}, 4'h0);
    apb(1'b0, 8'h1c, 8'h00);
    chk(err, 1'b1);
    apb(1'b1, `BTR_OFF, 8'ha5);
    rdc(`BTR_OFF, 8'h00);
    $display("reset and refusal test done");
    // Both modes; segment one kept at two quanta or more for triple mode
    for (int k = 0; k < 6; k++) begin
      t1 = $urandom_range(15, 1);
      t2 = $urandom_range(7, 0);
      btr = {1'(k % 2), 3'(t2), 4'(t1)};
      apb(1'b1, `CTRL_OFF, 8'h01);
      rdc(`CTRL_OFF, 8'h11);
      chk(init_ack, 1'b1);
      apb(1'b1, `BTR_OFF, btr);
      rdc(`BTR_OFF, btr);
      apb(1'b1, `CTRL_OFF, 8'h00);
      last = -1;
      repeat (5) begin
        while (rx_bit_valid !== 1'b1) @(posedge pclk);
        f[0] = btr[7] ? maj(hist) : hist[0];
        chk(rx_bit, f[0]);
        if (last >= 0) chk(cyc - last, 4 * (3 + t1 + t2));
        last = cyc;
        @(posedge pclk);
      end
      // Last bit read back through the status word
      apb(1'b0, `BITSTAT_OFF, 8'h00);
      chk(rd[0], f[0]);
    end
    $display("sampling test done");
    repeat (6) begin
      en = 8'($urandom_range(7, 0));
      f = 8'($urandom_range(7, 0));
      tx_empty <= f[2:0];
      apb(1'b1, `TIER_OFF, en);
      rdc(`TFLG_OFF, f);
      chk(irq_t, |(en & f));
    end
    // Receive and overrun flags, each set twice and cleared
    apb(1'b1, `RIER_OFF, 8'hc3);
    for (int i = 0; i < 4; i++) begin
      pulse(i[1]);
      chk(irq_r, !i[1]);
      chk(irq_e, i[1]);
      rdc(`RFLG_OFF, i[1] ? 8'h02 : 8'h01);
      apb(1'b1, `RFLG_OFF, 8'hff);
      repeat (2) @(posedge pclk);
      chk({irq_r, irq_e}, 2'h0);
    end
    apb(1'b1, `RIER_OFF, 8'h00);
    pulse(1'b0);
    chk(irq_r, 1'b0);
    apb(1'b1, `RFLG_OFF, 8'hff);
    apb(1'b1, `RIER_OFF, 8'hc3);
    $display("event test done");
    pts = 2'h0;
    prs = 2'h0;
    foreach (tx_tab[j]) begin
      tx_cnt <= 9'(tx_tab[j]);
      rx_cnt <= 8'($urandom_range(255, 0));
      repeat (4) @(posedge pclk);
      ts = code(tx_cnt);
      rs = code(rx_cnt);
      f = {1'b0, (ts != pts && ts != 0) || (rs != prs && rs != 0), rs, ts,
        2'h0};
      chk(irq_e, f[6]);
      rdc(`RFLG_OFF, f);
      apb(1'b1, `RFLG_OFF, 8'h40);
      pts = ts;
      prs = rs;
    end
    $display("bus state test done");
    // Bus activity in sleep only wakes with the wake function on
    sleep_mode <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(irq_w, 1'b0);
    apb(1'b1, `CTRL_OFF, 8'h02);
    last = 0;
    while (irq_w !== 1'b1 && last < 200) begin
      @(posedge pclk);
      last++;
    end
    chk(irq_w, 1'b1);
    rdc(`RFLG_OFF, {2'h2, code(rx_cnt), code(tx_cnt), 2'h0});
    $display("wake test done");
    test_done;
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
